// [hdl/rhcs_pkg.sv]
/*
 * Constants for the run/hold current selection block: register map,
 * field positions, reset values, divider counts and the current table.
 * Assumes a 10 MHz system clock and an APB register port.
 */
package rhcs_pkg;
    localparam int          CLK_HZ          = 10000000;
    localparam int          PWM_HZ          = 20000;
    localparam int          PWM_CYCLES      = CLK_HZ / PWM_HZ;
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_CURRENT    = 12'h004;
    localparam logic [11:0] ADDR_STATUS     = 12'h008;
    localparam logic [11:0] ADDR_POSITION   = 12'h00C;
    localparam int          CTRL_RHP_BIT    = 0;
    localparam int          CTRL_ROTATION_SENSE_POLARITY_BIT   = 1;
    localparam int          CTRL_STEP_BIT   = 2;
    localparam int          CTRL_BOOST_BIT  = 3;
    localparam int          CTRL_MOTOR_DRIVE_ENABLE_BIT  = 4;
    localparam int          CTRL_SLEEP_BIT  = 5;
    localparam int          CUR_RUN_LSB     = 0;
    localparam int          CUR_HOLD_LSB    = 4;
    localparam logic [3:0]  RUN_CODE_RST    = 4'h0;
    localparam logic [3:0]  HOLD_CODE_RST   = 4'h0;
    localparam logic [6:0]  POS_RST         = 7'h00;
    localparam int          STAT_RHIN_BIT   = 0;
    localparam int          STAT_RUN_BIT    = 1;
    localparam int          STAT_BOOST_BIT  = 2;
    localparam int          STAT_DETEN_BIT  = 3;
    localparam int          STAT_DUTYZ_BIT  = 4;
    localparam int          STAT_AMP_LSB    = 16;
    localparam int          MA_RUN_MIN      = 59;
    localparam int          MA_RUN_MAX      = 800;
    localparam int          MA_BOOST_MAX    = 1100;
    typedef enum logic [0:0] {RHCS_HOLD, RHCS_RUN} rhcs_mode_t;
    // Peak current in mA per run code, unboosted then boosted
    localparam logic [10:0] MA_UNB [16] = '{11'd59, 11'd71, 11'd84, 11'd100,
        11'd119, 11'd141, 11'd168, 11'd200, 11'd238, 11'd283, 11'd336, 11'd400,
        11'd476, 11'd566, 11'd673, 11'd800};
    localparam logic [10:0] MA_BST [16] = '{11'd81, 11'd98, 11'd116, 11'd138,
        11'd164, 11'd194, 11'd231, 11'd275, 11'd327, 11'd389, 11'd462, 11'd550,
        11'd655, 11'd778, 11'd925, 11'd1100};
endpackage

// [hdl/rhcs_pwm_tick.sv]
/*
 * Divider that gives a one-cycle enable at the start of every PWM period.
 * Assumes one system clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module rhcs_pwm_tick #(
    parameter int PERIOD = 500
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Period start pulse
    output logic      tick
);
    initial begin
        if (PERIOD < 2 || PERIOD > 65535) begin
            $error("rhcs_pwm_tick: PERIOD out of range");
        end
    end

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    always_comb begin
        cnt_d = (cnt_q == 16'(PERIOD - 1)) ? 16'h0000 : cnt_q + 16'h0001;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = (cnt_q == 16'(PERIOD - 1));
endmodule

// [hdl/rhcs_top.sv]
/*
 * Run/hold mode and coil current amplitude selection with APB registers.
 * Assumes MCLK at 10 MHz, pins synchronous to MCLK, a thermal warning
 * level from the analog side, and a regulation stage taking the code.
 */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module rhcs_top #(
    parameter int PWM_PERIOD = rhcs_pkg::PWM_CYCLES
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Device pins and analog status
    input  wire logic        RUN_HOLD_INPUT,
    input  wire logic        STEP_ADVANCE_INPUT,
    input  wire logic        DIR_INPUT,
    input  wire logic        THERMAL_WARNING_LEVEL,
    // Toward translator and regulation stage
    output logic      [6:0]  POSITION,
    output logic      [3:0]  AMP_CODE,
    output logic             AMP_ZERO,
    output logic             BOOST_ACTIVE,
    output logic             BRIDGE_ENABLE,
    output logic             DETECT_ENABLE,
    output logic             DUTY_ZERO
);
    import rhcs_pkg::*;

    initial begin
        if (PWM_PERIOD < 2) begin
            $error("rhcs_top: PWM_PERIOD too small");
        end
    end

    logic pwm_tick;

    rhcs_pwm_tick #(
        .PERIOD (PWM_PERIOD)
    ) u_tick (
        .clk  (MCLK),
        .rst  (RST),
        .tick (pwm_tick)
    );

    // Register state
    logic       rhp_q,   rhp_d;
    logic       rotation_sense_polarity_q,  rotation_sense_polarity_d;
    logic       stepc_q, stepc_d;
    logic       boost_q, boost_d;
    logic       motor_drive_enable_q, motor_drive_enable_d;
    logic       sleep_q, sleep_d;
    logic [3:0] run_q,   run_d;
    logic [3:0] hold_q,  hold_d;
    logic [31:0] rdata_q, rdata_d;

    // Mode and motion state
    logic       step_pin_q, step_pin_d;
    logic [6:0] pos_q,      pos_d;
    logic [3:0] amp_q,      amp_d;
    logic       azero_q,    azero_d;
    logic       bst_q,      bst_d;
    logic       hz_q,       hz_d;

    rhcs_mode_t mode;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;
    logic       step_evt;
    logic       dir_eff;
    logic       boost_eff;

    // Read data is latched in setup so it stands through the access cycle
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && !PENABLE && !PWRITE;
    assign addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_CURRENT) ||
                     (PADDR == ADDR_STATUS) || (PADDR == ADDR_POSITION);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    assign mode      = (RUN_HOLD_INPUT ^ rhp_q) ? RHCS_RUN : RHCS_HOLD;
    assign dir_eff   = DIR_INPUT ^ rotation_sense_polarity_q;
    assign boost_eff = boost_q && !THERMAL_WARNING_LEVEL;
    // Pin edge or pending command, taken only while awake
    assign step_evt  = !sleep_q && ((STEP_ADVANCE_INPUT && !step_pin_q) || stepc_q);

    always_comb begin
        rhp_d   = rhp_q;
        rotation_sense_polarity_d  = rotation_sense_polarity_q;
        boost_d = boost_q;
        motor_drive_enable_d = motor_drive_enable_q;
        sleep_d = sleep_q;
        run_d   = run_q;
        hold_d  = hold_q;
        stepc_d = stepc_q;
        if (step_evt) begin
            stepc_d = 1'b0;
        end
        if (wr_en && PADDR == ADDR_CTRL && PSTRB[0]) begin
            rhp_d   = PWDATA[CTRL_RHP_BIT];
            rotation_sense_polarity_d  = PWDATA[CTRL_ROTATION_SENSE_POLARITY_BIT];
            boost_d = PWDATA[CTRL_BOOST_BIT];
            motor_drive_enable_d = PWDATA[CTRL_MOTOR_DRIVE_ENABLE_BIT];
            sleep_d = PWDATA[CTRL_SLEEP_BIT];
            // A new command wins over the self-clear
            if (PWDATA[CTRL_STEP_BIT]) begin
                stepc_d = 1'b1;
            end
        end
        if (wr_en && PADDR == ADDR_CURRENT && PSTRB[0]) begin
            run_d  = PWDATA[CUR_RUN_LSB +: 4];
            hold_d = PWDATA[CUR_HOLD_LSB +: 4];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_en) begin
            case (PADDR)
                ADDR_CTRL: begin
                    rdata_d[CTRL_RHP_BIT]   = rhp_q;
                    rdata_d[CTRL_ROTATION_SENSE_POLARITY_BIT]  = rotation_sense_polarity_q;
                    rdata_d[CTRL_STEP_BIT]  = stepc_q;
                    rdata_d[CTRL_BOOST_BIT] = boost_q;
                    rdata_d[CTRL_MOTOR_DRIVE_ENABLE_BIT] = motor_drive_enable_q;
                    rdata_d[CTRL_SLEEP_BIT] = sleep_q;
                end
                ADDR_CURRENT: begin
                    rdata_d[CUR_RUN_LSB +: 4]  = run_q;
                    rdata_d[CUR_HOLD_LSB +: 4] = hold_q;
                end
                ADDR_STATUS: begin
                    rdata_d[STAT_RHIN_BIT]     = RUN_HOLD_INPUT;
                    rdata_d[STAT_RUN_BIT]      = (mode == RHCS_RUN);
                    rdata_d[STAT_BOOST_BIT]    = bst_q;
                    rdata_d[STAT_DETEN_BIT]    = DETECT_ENABLE;
                    rdata_d[STAT_DUTYZ_BIT]    = hz_q;
                    rdata_d[STAT_AMP_LSB +: 4] = amp_q;
                end
                ADDR_POSITION: begin
                    rdata_d[6:0] = pos_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rhp_q   <= 1'b0;
            rotation_sense_polarity_q  <= 1'b0;
            stepc_q <= 1'b0;
            boost_q <= 1'b0;
            motor_drive_enable_q <= 1'b0;
            sleep_q <= 1'b0;
            run_q   <= RUN_CODE_RST;
            hold_q  <= HOLD_CODE_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            rhp_q   <= rhp_d;
            rotation_sense_polarity_q  <= rotation_sense_polarity_d;
            stepc_q <= stepc_d;
            boost_q <= boost_d;
            motor_drive_enable_q <= motor_drive_enable_d;
            sleep_q <= sleep_d;
            run_q   <= run_d;
            hold_q  <= hold_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        step_pin_d = STEP_ADVANCE_INPUT;
        pos_d      = pos_q;
        amp_d      = amp_q;
        azero_d    = azero_q;
        bst_d      = bst_q;
        hz_d       = hz_q;
        // Mode gating holds even with the bridges off
        if (step_evt && mode == RHCS_RUN) begin
            pos_d = dir_eff ? pos_q + 7'h01 : pos_q - 7'h01;
        end
        // Hold code n is run code n-1; hold 0 means no current
        if (pwm_tick && !sleep_q) begin
            if (mode == RHCS_RUN) begin
                amp_d   = run_q;
                azero_d = 1'b0;
                hz_d    = 1'b0;
            end else begin
                amp_d   = (hold_q == 4'h0) ? 4'h0 : hold_q - 4'h1;
                azero_d = (hold_q == 4'h0);
                hz_d    = (hold_q == 4'h0);
            end
            bst_d = boost_eff;
        end
        if (THERMAL_WARNING_LEVEL) begin
            bst_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            step_pin_q <= 1'b0;
            pos_q      <= POS_RST;
            amp_q      <= 4'h0;
            azero_q    <= 1'b1;
            bst_q      <= 1'b0;
            hz_q       <= 1'b0;
        end else begin
            step_pin_q <= step_pin_d;
            if (!sleep_q) begin
                pos_q <= pos_d;
            end
            amp_q   <= amp_d;
            azero_q <= azero_d;
            bst_q   <= bst_d;
            hz_q    <= hz_d;
        end
    end

    assign PRDATA        = rdata_q;
    assign POSITION      = pos_q;
    assign AMP_CODE      = amp_q;
    assign AMP_ZERO      = azero_q;
    assign BOOST_ACTIVE  = bst_q;
    assign BRIDGE_ENABLE = motor_drive_enable_q && !sleep_q;
    assign DETECT_ENABLE = !hz_q && !sleep_q;
    assign DUTY_ZERO     = hz_q || azero_q;

    a_hold_freezes_pos: assert property (@(posedge MCLK) disable iff (RST)
        (mode == RHCS_HOLD) |=> $stable(pos_q))
        else $error("position moved in hold");
    a_run_step_moves: assert property (@(posedge MCLK) disable iff (RST)
        (step_evt && mode == RHCS_RUN && dir_eff) |=> pos_q == $past(pos_q) + 7'h01)
        else $error("run step did not advance");
    a_boost_thermal_off: assert property (@(posedge MCLK) disable iff (RST)
        THERMAL_WARNING_LEVEL |=> !bst_q)
        else $error("boost active above thermal warning");
    a_cmd_self_clear: assert property (@(posedge MCLK) disable iff (RST)
        (stepc_q && !sleep_q && !(wr_en && PADDR == ADDR_CTRL)) |=> !stepc_q)
        else $error("step command did not clear");
    a_amp_on_tick: assert property (@(posedge MCLK) disable iff (RST)
        (!pwm_tick && !THERMAL_WARNING_LEVEL) |=> $stable(amp_q) && $stable(bst_q))
        else $error("amplitude changed outside period start");
    a_hold_zero_det: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && mode == RHCS_HOLD && hold_q == 4'h0)
        |=> !DETECT_ENABLE && DUTY_ZERO)
        else $error("detection not disabled at zero hold");
    a_hold_code_map: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && mode == RHCS_HOLD && hold_q != 4'h0)
        |=> amp_q == $past(hold_q) - 4'h1)
        else $error("hold code mapping wrong");
    a_sleep_no_move: assert property (@(posedge MCLK) disable iff (RST)
        sleep_q |=> $stable(pos_q))
        else $error("position moved in sleep");

    // Amplitude selection per period
    a_run_amp_code: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && mode == RHCS_RUN) |=> AMP_CODE == $past(run_q))
        else $error("run code not selected");
    a_run_not_zero: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && mode == RHCS_RUN) |=> !AMP_ZERO)
        else $error("zero current flagged in run");
    a_hold_amp_zero: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && mode == RHCS_HOLD && hold_q == 4'h0) |=> AMP_CODE == 4'h0 && AMP_ZERO)
        else $error("zero hold code not zero current");
    a_run_detect_on: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && mode == RHCS_RUN) |=> !hz_q)
        else $error("detection left off in run");
    a_code_write_wait: assert property (@(posedge MCLK) disable iff (RST)
        (wr_en && PADDR == ADDR_CURRENT && !pwm_tick) |=> $stable(amp_q))
        else $error("current code applied before period start");

    // Stepping
    a_run_step_back: assert property (@(posedge MCLK) disable iff (RST)
        (step_evt && mode == RHCS_RUN && !dir_eff) |=> pos_q == $past(pos_q) - 7'h01)
        else $error("reverse step did not go back");
    a_step_any_drive: assert property (@(posedge MCLK) disable iff (RST)
        (step_evt && mode == RHCS_RUN && !motor_drive_enable_q) |=> pos_q != $past(pos_q))
        else $error("step lost with drive disabled");
    a_pos_idle: assert property (@(posedge MCLK) disable iff (RST)
        !step_evt |=> $stable(pos_q))
        else $error("position moved without a step");

    // Status read-back
    a_status_mode: assert property (@(posedge MCLK) disable iff (RST)
        (rd_en && PADDR == ADDR_STATUS) |=> PRDATA[STAT_RUN_BIT] == $past(RUN_HOLD_INPUT ^ rhp_q))
        else $error("status run flag wrong");
    a_status_boost: assert property (@(posedge MCLK) disable iff (RST)
        (rd_en && PADDR == ADDR_STATUS) |=> PRDATA[STAT_BOOST_BIT] == $past(bst_q))
        else $error("status boost flag wrong");
    a_status_pin: assert property (@(posedge MCLK) disable iff (RST)
        (rd_en && PADDR == ADDR_STATUS) |=> PRDATA[STAT_RHIN_BIT] == $past(RUN_HOLD_INPUT))
        else $error("status pin flag wrong");
    a_status_duty: assert property (@(posedge MCLK) disable iff (RST)
        (rd_en && PADDR == ADDR_STATUS) |=> PRDATA[STAT_DUTYZ_BIT] == $past(hz_q))
        else $error("status duty flag wrong");
    a_unmapped_read: assert property (@(posedge MCLK) disable iff (RST)
        (rd_en && !addr_ok) |=> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Boost
    a_boost_grant: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && boost_q && !THERMAL_WARNING_LEVEL) |=> BOOST_ACTIVE)
        else $error("boost not granted");
    a_boost_no_req: assert property (@(posedge MCLK) disable iff (RST)
        (pwm_tick && !sleep_q && !boost_q) |=> !BOOST_ACTIVE)
        else $error("boost active without request");

    // Command and sleep
    a_cmd_sets_step: assert property (@(posedge MCLK) disable iff (RST)
        (wr_en && PADDR == ADDR_CTRL && PSTRB[0] && PWDATA[CTRL_STEP_BIT]) |=> stepc_q)
        else $error("step command not taken");
    a_sleep_amp_hold: assert property (@(posedge MCLK) disable iff (RST)
        (sleep_q && !THERMAL_WARNING_LEVEL) |=> $stable(amp_q) && $stable(bst_q))
        else $error("amplitude changed in sleep");
endmodule

// [sim/rhcs_mcu_model.sv]
/*
 * Pin side of the controlling microcontroller: run/hold, direction, step.
 * Assumes the bench requests pin levels; pins move only after MCLK edges.
 */
`timescale 1ns/1ps
module rhcs_mcu_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Requested levels
    input  wire logic rh_req,
    input  wire logic dir_req,
    input  wire logic step_req,
    // Device pins
    output logic      rh_pin,
    output logic      dir_pin,
    output logic      step_pin
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rh_pin   <= 1'b0;
            dir_pin  <= 1'b0;
            step_pin <= 1'b0;
        end else begin
            rh_pin   <= rh_req;
            dir_pin  <= dir_req;
            step_pin <= step_req;
        end
    end
endmodule

// [sim/tb_top.sv]
/*
 * Self-checking bench for rhcs_top: table of mode and current cases, then
 * steps, drive disable, sleep and an unmapped access. Assumes PWM_PERIOD 8.
 */
`timescale 1ns/1ps
module tb_top;
    import rhcs_pkg::*;
    typedef struct packed {
        logic [3:0] run, hold, amp;
        logic       rh, rhp, bst, tw, zero, bact;
        logic [1:0] pad;
    } rhcs_row_t;
    localparam rhcs_row_t ROWS [7] = '{20'h53580, 20'hA3A40, 20'h532C0, 20'hF002C,
                                       20'hF1000, 20'hF0FB0, 20'h0F0A4};
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, tw;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        rh_req, dir_req, step_req, rh_pin, dir_pin, step_pin;
    logic [6:0]  position;
    logic [3:0]  amp_code;
    logic        amp_zero, boost_act, bridge_en, detect_en, duty_zero;
    int          n_errors, num_checks;

    rhcs_mcu_model MCU (.clk(mclk), .rst(rst), .rh_req(rh_req), .dir_req(dir_req),
        .step_req(step_req), .rh_pin(rh_pin), .dir_pin(dir_pin), .step_pin(step_pin));

    rhcs_top #(.PWM_PERIOD(8)) DUT (.MCLK(mclk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RUN_HOLD_INPUT(rh_pin), .STEP_ADVANCE_INPUT(step_pin), .DIR_INPUT(dir_pin),
        .THERMAL_WARNING_LEVEL(tw), .POSITION(position), .AMP_CODE(amp_code),
        .AMP_ZERO(amp_zero), .BOOST_ACTIVE(boost_act), .BRIDGE_ENABLE(bridge_en),
        .DETECT_ENABLE(detect_en), .DUTY_ZERO(duty_zero));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One APB transfer; read data and error are taken at the edge that sees ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            complete_run();
        end
        err = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    function automatic logic [31:0] ctrl(input logic rhp, rotation_sense_polarity, stp, bst, mot, slp);
        return {26'h0, slp, mot, bst, stp, rotation_sense_polarity, rhp};
    endfunction

    task automatic pulse;
        step_req <= 1'b1;
        cyc(3);
        step_req <= 1'b0;
        cyc(3);
    endtask

    initial begin
        logic [31:0] q;
        logic        e;
        int          k;
        rhcs_row_t   r;
        rst = 1'b1;
        {psel, penable, pwrite, tw, rh_req, dir_req, step_req} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        num_checks = 0;
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        check(position, 7'h00);
        check(bridge_en, 1'h0);
        for (int i = 0; i < 7; i++) begin
            r = ROWS[i];
            wr(ADDR_CTRL, ctrl(r.rhp, 1'b0, 1'b0, r.bst, 1'b1, 1'b0));
            wr(ADDR_CURRENT, {24'h0, r.hold, r.run});
            rh_req <= r.rh;
            tw <= r.tw;
            cyc(12);
            check(amp_code, r.amp);
            check(amp_zero, r.zero);
            check(boost_act, r.bact);
            check(detect_en, !r.zero);
            check(duty_zero, r.zero);
            apb(1'b0, ADDR_STATUS, 32'h0, q, e);
            check(q[2:0], {r.bact, r.rh ^ r.rhp, r.rh});
        end
        tw <= 1'b0;
        wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
        rh_req <= 1'b1;
        dir_req <= 1'b1;
        cyc(3);
        check(bridge_en, 1'h1);
        pulse();
        check(position, 7'h01);
        wr(ADDR_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
        pulse();
        pulse();
        check(position, 7'h7F);
        wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
        cyc(3);
        check(position, 7'h00);
        apb(1'b0, ADDR_CTRL, 32'h0, q, e);
        check(q[CTRL_STEP_BIT], 1'h0);
        rh_req <= 1'b0;
        cyc(3);
        pulse();
        wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
        cyc(3);
        check(position, 7'h00);
        wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        rh_req <= 1'b1;
        cyc(3);
        check(bridge_en, 1'h0);
        pulse();
        check(position, 7'h01);
        wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
        pulse();
        check(position, 7'h01);
        check(bridge_en, 1'h0);
        wr(ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
        wr(ADDR_CURRENT, 32'h00000037);
        k = 0;
        while (amp_code !== 4'h7 && k < 10) begin
            cyc(1);
            k++;
        end
        check(amp_code, 4'h7);
        apb(1'b0, ADDR_POSITION, 32'h0, q, e);
        check(q, 32'h00000001);
        apb(1'b0, 12'h010, 32'h0, q, e);
        check(e, 1'h1);
        check(q, 32'h0);
        rst <= 1'b1;
        cyc(2);
        check(position, POS_RST);
        check(amp_code, 4'h0);
        check(amp_zero, 1'h1);
        check(bridge_en, 1'h0);
        check(duty_zero, 1'h1);
        rst <= 1'b0;
        cyc(1);
        apb(1'b0, ADDR_CURRENT, 32'h0, q, e);
        check(q, {24'h0, HOLD_CODE_RST, RUN_CODE_RST});
        complete_run();
    end
endmodule
